// *** rtl/srp_regs.svh ***
// What this block does
// [R1] Header: command bit, two reserved, 5-bit address
// [R2] Command zero: store data byte at address
// [R3] Command one: return register at address
// [R4] Extra bytes use incremented consecutive addresses
// [R5] Master sends address, data MSB first
// [R6] Read address in, data out, MSB first
// [R7] Master drives header/write bits, device samples next
// [R8] Device drives read bits, master samples next
// [R9] Master holds select, clocks for more bytes
// [R10] Frames end on whole byte boundaries
// [R11] Device releases data output when not reading
// [R12] Clock level at select fall picks edges
// [R13] Edge choice fixed until next select fall
// [R14] Partial byte at select rise is dropped
// [R15] Address wraps past 31 to zero
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SRP_BYTE_W      8
`define SRP_ADDR_W      5
`define SRP_NREG        32
`define SRP_CMD_POS     7
`define SRP_ADDR_LSB    0
`define SRP_CMD_WRITE   1'b0
`define SRP_CMD_READ    1'b1
`define SRP_RSVD_BITS   2'b00
`define SRP_REG_RST     8'h00
`define SRP_FIFO_DEPTH  8
`define SRP_LEN_W       6

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRP_CLK_NS      5
`define SRP_SCLK_HALF_NS 2000
`define SRP_SCLK_HALF_CYC ((`SRP_SCLK_HALF_NS + `SRP_CLK_NS - 1) / `SRP_CLK_NS)
`define SRP_CPS_NS      20
`define SRP_CPS_CYC     ((`SRP_CPS_NS + `SRP_CLK_NS - 1) / `SRP_CLK_NS)
`define SRP_CSH_NS      20
`define SRP_CSH_CYC     ((`SRP_CSH_NS + `SRP_CLK_NS - 1) / `SRP_CLK_NS)
`define SRP_TMR_W       10

`endif

// *** rtl/srp_pkg.sv ***
`default_nettype none
`include "srp_regs.svh"

package srp_pkg;

  // ----------------------------------------
  // Shared types
  // ----------------------------------------
  typedef logic [`SRP_BYTE_W-1:0] srp_byte_t;
  typedef logic [`SRP_ADDR_W-1:0] srp_addr_t;
  typedef logic [`SRP_LEN_W-1:0]  srp_len_t;

  // Write event handed to the system side
  typedef struct packed {
    srp_addr_t addr;
    srp_byte_t data;
  } srp_wr_s;

  // Master sequencer states
  typedef enum logic [2:0] {
    SRP_IDLE,
    SRP_SETUP,
    SRP_LEAD,
    SRP_XFER,
    SRP_SAMP,
    SRP_LOAD,
    SRP_HOLD
  } srp_mst_e;

endpackage

`default_nettype wire

// *** rtl/srp_link_if.sv ***
`default_nettype none

// ----------------------------------------
// Four-wire serial link between the ends
// ----------------------------------------
interface srp_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // Released line reads as pulled high
  assign miso = miso_oe ? miso_o : 1'b1;

  modport dev (input sclk, input cs_n, input mosi, output miso_o, output miso_oe);
  modport mst (output sclk, output cs_n, output mosi, input miso);
endinterface

`default_nettype wire

// *** rtl/srp_fifo.sv ***
`default_nettype none

// ----------------------------------------
// Small synchronous FIFO
// ----------------------------------------
module srp_fifo #(
  parameter int W = 13,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_s;

  fifo_s s_q;
  fifo_s s_d;
  logic  push;
  logic  pop;

  // Honest flags straight from the fill count
  assign in_ready  = (s_q.cnt != (AW+1)'(D));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = (s_q.wp == AW'(D-1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop)
      s_d.rp = (s_q.rp == AW'(D-1)) ? '0 : s_q.rp + 1'b1;
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule

`default_nettype wire

// *** rtl/srp_device.sv ***
`default_nettype none
`include "srp_regs.svh"

// ----------------------------------------
// Device end: serial register port
// ----------------------------------------
module srp_device (
  input  wire logic         CLOCK,
  input  wire logic         RESET_N,
  srp_link_if.dev           LINK,
  output logic              WR_VALID,
  input  wire logic         WR_READY,
  output srp_pkg::srp_addr_t WR_ADDR,
  output srp_pkg::srp_byte_t WR_DATA,
  output logic              ACTIVE,
  output logic              OVERFLOW,
  input  wire logic         OVF_CLR
);
  import srp_pkg::*;

  // ----------------------------------------
  // Edge selection
  // ----------------------------------------
  // Clock level caught at select fall; stays put all frame
  logic pol_q;
  logic samp_clk;

  always_ff @(negedge LINK.cs_n or negedge RESET_N)
  begin
    if (!RESET_N)
      pol_q <= 1'b0;
    else
      pol_q <= LINK.sclk;  // [R12] [R13]
  end

  // Sampling clock: level low means sample on falling edges.
  // Glitch at select fall is harmless, frame state loads zero until armed.
  assign samp_clk = LINK.sclk ^ ~pol_q;  // [R12]

  // ----------------------------------------
  // Frame state, cleared whenever select is high
  // ----------------------------------------
  typedef struct packed {
    logic      hdr_done;
    logic      rw;
    srp_addr_t addr;
    logic [2:0] cnt;
    logic [6:0] sh;
    srp_byte_t rd_byte;
  } frm_s;

  // Register file and write hand-off survive between frames
  typedef struct packed {
    logic [`SRP_NREG-1:0][`SRP_BYTE_W-1:0] regs;
    srp_wr_s hold;
    logic    tog;
  } per_s;

  frm_s      f_q;
  frm_s      f_d;
  per_s      p_q;
  per_s      p_d;
  srp_byte_t byte_in;
  logic      byte_done;
  srp_addr_t addr_nx;

  // Read driver state; armed marks the first transfer edge of a frame
  typedef struct packed {
    logic armed;
    logic oe;
    logic bit_o;
  } out_s;

  out_s o_q;
  out_s o_d;

  assign byte_in   = {f_q.sh, LINK.mosi};  // [R5] [R6]
  assign byte_done = (f_q.cnt == 3'h7);    // [R10]
  assign addr_nx   = f_q.addr + 1'b1;      // [R15]

  // Bit assembly on the sampling edge
  always_comb
  begin
    f_d     = f_q;
    p_d     = p_q;
    f_d.cnt = f_q.cnt + 1'b1;
    f_d.sh  = byte_in[6:0];  // [R7]
    if (byte_done)
    begin
      if (!f_q.hdr_done)
      begin
        // Reserved bits are ignored
        f_d.hdr_done = 1'b1;
        f_d.rw       = byte_in[`SRP_CMD_POS];  // [R1]
        f_d.addr     = byte_in[`SRP_ADDR_LSB +: `SRP_ADDR_W];  // [R1]
        f_d.rd_byte  = p_q.regs[byte_in[`SRP_ADDR_LSB +: `SRP_ADDR_W]];  // [R3]
      end
      else
      begin
        if (f_q.rw == `SRP_CMD_WRITE)
        begin
          p_d.regs[f_q.addr] = byte_in;  // [R2]
          p_d.hold.addr      = f_q.addr;
          p_d.hold.data      = byte_in;
          p_d.tog            = ~p_q.tog;
        end
        f_d.addr    = addr_nx;             // [R4] [R15]
        f_d.rd_byte = p_q.regs[addr_nx];   // [R4]
      end
    end
    // Edge flip at select fall can glitch the sampling clock; ignore it
    if (!o_q.armed)
      f_d = '0;  // [R13]
  end

  // Select high drops any partial byte without a write
  always_ff @(posedge samp_clk or posedge LINK.cs_n)
  begin
    if (LINK.cs_n)
      f_q <= '0;  // [R14]
    else
      f_q <= f_d;
  end

  // Register file only changes on a whole byte
  always_ff @(posedge samp_clk or negedge RESET_N)
  begin
    if (!RESET_N)
      p_q <= '0;
    else
      p_q <= p_d;
  end

  // ----------------------------------------
  // Read data driver on the transfer edge
  // ----------------------------------------
  // Drive only in the data section of a read
  always_comb
  begin
    o_d.armed = 1'b1;
    o_d.oe    = f_q.hdr_done && (f_q.rw == `SRP_CMD_READ);  // [R8] [R11]
    o_d.bit_o = f_q.rd_byte[3'h7 - f_q.cnt];                // [R6] [R8]
  end

  always_ff @(negedge samp_clk or posedge LINK.cs_n)
  begin
    if (LINK.cs_n)
      o_q <= '0;  // [R11]
    else
      o_q <= o_d;
  end

  assign LINK.miso_o  = o_q.bit_o;
  assign LINK.miso_oe = o_q.oe;  // [R11]

  // ----------------------------------------
  // Crossing into the system clock
  // ----------------------------------------
  // Hold word stays stable for a whole byte after each toggle,
  // far longer than the three-flop toggle path.
  typedef struct packed {
    logic    tog_m;
    logic    tog_s;
    logic    tog_p;
    logic    act_m;
    logic    act_s;
    logic    pend;
    srp_wr_s word;
    logic    ovf;
  } sys_s;

  sys_s    s_q;
  sys_s    s_d;
  logic    fifo_in_ready;
  srp_wr_s fifo_out;
  logic    new_wr;

  assign new_wr = s_q.tog_s ^ s_q.tog_p;

  // Pending word waits for FIFO room; a second one meanwhile is lost
  always_comb
  begin
    s_d       = s_q;
    s_d.tog_m = p_q.tog;
    s_d.tog_s = s_q.tog_m;
    s_d.tog_p = s_q.tog_s;
    s_d.act_m = ~LINK.cs_n;
    s_d.act_s = s_q.act_m;
    if (s_q.pend && fifo_in_ready)
      s_d.pend = 1'b0;
    if (new_wr)
    begin
      if (s_q.pend && !fifo_in_ready)
        s_d.ovf = 1'b1;  // Newest word dropped, pending one kept
      else
      begin
        s_d.pend = 1'b1;
        s_d.word = p_q.hold;
      end
    end
    // Overflow set wins over the clear
    if (OVF_CLR && !(new_wr && s_q.pend && !fifo_in_ready))
      s_d.ovf = 1'b0;
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Write stream buffer toward the system
  srp_fifo #(
    .W ($bits(srp_wr_s)),
    .D (`SRP_FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RESET_N),
    .in_valid  (s_q.pend),
    .in_ready  (fifo_in_ready),
    .in_data   (s_q.word),
    .out_valid (WR_VALID),
    .out_ready (WR_READY),
    .out_data  (fifo_out)
  );

  assign WR_ADDR  = fifo_out.addr;
  assign WR_DATA  = fifo_out.data;
  assign ACTIVE   = s_q.act_s;
  assign OVERFLOW = s_q.ovf;
endmodule

`default_nettype wire

// *** rtl/srp_master.sv ***
`default_nettype none
`include "srp_regs.svh"

// ----------------------------------------
// Master end: drives frames onto the link
// ----------------------------------------
module srp_master (
  input  wire logic          CLOCK,
  input  wire logic          RESET_N,
  srp_link_if.mst            LINK,
  input  wire logic          CMD_VALID,
  output logic               CMD_READY,
  input  wire logic          CMD_RW,
  input  wire logic          CMD_CPOL,
  input  wire srp_pkg::srp_addr_t CMD_ADDR,
  input  wire srp_pkg::srp_len_t  CMD_LEN,
  input  wire logic          WD_VALID,
  output logic               WD_READY,
  input  wire srp_pkg::srp_byte_t WD_DATA,
  output logic               RD_VALID,
  output srp_pkg::srp_byte_t RD_DATA
);
  import srp_pkg::*;

  typedef struct packed {
    srp_mst_e  st;
    logic      sclk;
    logic      cs_n;
    logic      mosi;
    logic      cpol;
    logic      rw;
    logic      hdr;
    logic [`SRP_TMR_W-1:0] tmr;
    logic [2:0] bitn;
    srp_len_t  left;
    srp_byte_t sh;
    srp_byte_t rx;
    logic      miso_m;
    logic      miso_s;
    logic      rd_v;
    srp_byte_t rd_d;
  } mst_s;

  localparam logic [`SRP_TMR_W-1:0] HALF = `SRP_TMR_W'(`SRP_SCLK_HALF_CYC - 1);
  localparam logic [`SRP_TMR_W-1:0] CPS  = `SRP_TMR_W'(`SRP_CPS_CYC - 1);
  localparam logic [`SRP_TMR_W-1:0] CSH  = `SRP_TMR_W'(`SRP_CSH_CYC - 1);

  mst_s m_q;
  mst_s m_d;
  logic tdone;

  assign tdone     = (m_q.tmr == '0);
  assign CMD_READY = (m_q.st == SRP_IDLE);
  assign WD_READY  = (m_q.st == SRP_LOAD) && (m_q.rw == `SRP_CMD_WRITE);

  // Sequencer: one bit is a transfer half and a sample half
  always_comb
  begin
    m_d        = m_q;
    m_d.miso_m = LINK.miso;
    m_d.miso_s = m_q.miso_m;
    m_d.rd_v   = 1'b0;
    m_d.tmr    = tdone ? '0 : m_q.tmr - 1'b1;
    case (m_q.st)
      SRP_IDLE:
      begin
        if (CMD_VALID)
        begin
          m_d.cpol = CMD_CPOL;
          m_d.sclk = CMD_CPOL;  // [R12]
          m_d.rw   = CMD_RW;
          m_d.left = CMD_LEN;
          m_d.sh   = {CMD_RW, `SRP_RSVD_BITS, CMD_ADDR};  // [R1] [R5]
          m_d.tmr  = CPS;
          m_d.st   = SRP_SETUP;
        end
      end
      SRP_SETUP:
        if (tdone)
        begin
          m_d.cs_n = 1'b0;
          m_d.hdr  = 1'b1;
          m_d.tmr  = CPS;
          m_d.st   = SRP_LEAD;
        end
      SRP_LEAD:
        if (tdone)
        begin
          m_d.sclk = ~m_q.cpol;
          m_d.mosi = m_q.sh[7];  // [R7]
          m_d.tmr  = HALF;
          m_d.st   = SRP_XFER;
        end
      SRP_XFER:
        if (tdone)
        begin
          m_d.sclk = m_q.cpol;
          m_d.rx   = {m_q.rx[6:0], m_q.miso_s};  // [R8]
          m_d.sh   = {m_q.sh[6:0], 1'b0};
          m_d.tmr  = HALF;
          m_d.st   = SRP_SAMP;
        end
      SRP_SAMP:
        if (tdone)
        begin
          m_d.bitn = m_q.bitn + 1'b1;
          if (m_q.bitn != 3'h7)
          begin
            m_d.sclk = ~m_q.cpol;
            m_d.mosi = m_q.sh[7];  // [R5] [R7]
            m_d.tmr  = HALF;
            m_d.st   = SRP_XFER;
          end
          else
          begin
            m_d.hdr  = 1'b0;
            m_d.rd_v = !m_q.hdr && (m_q.rw == `SRP_CMD_READ);  // [R6]
            m_d.rd_d = m_q.rx;
            if (!m_q.hdr)
              m_d.left = m_q.left - 1'b1;
            m_d.tmr = CSH;
            m_d.st  = ((m_q.hdr || m_q.left != srp_len_t'(1)) && m_q.left != '0)
                      ? SRP_LOAD : SRP_HOLD;  // [R9] [R10]
          end
        end
      SRP_LOAD:
        if (m_q.rw == `SRP_CMD_READ || WD_VALID)
        begin
          m_d.sh   = WD_DATA;
          m_d.sclk = ~m_q.cpol;
          m_d.mosi = (m_q.rw == `SRP_CMD_READ) ? 1'b0 : WD_DATA[7];
          m_d.tmr  = HALF;
          m_d.st   = SRP_XFER;
        end
      SRP_HOLD:
        if (tdone)
        begin
          m_d.cs_n = 1'b1;
          m_d.st   = SRP_IDLE;
        end
      default:
        m_d.st = SRP_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      m_q      <= '0;
      m_q.cs_n <= 1'b1;
      m_q.st   <= SRP_IDLE;
    end
    else
      m_q <= m_d;
  end

  assign LINK.sclk = m_q.sclk;
  assign LINK.cs_n = m_q.cs_n;
  assign LINK.mosi = m_q.mosi;
  assign RD_VALID  = m_q.rd_v;
  assign RD_DATA   = m_q.rd_d;
endmodule

`default_nettype wire

// *** verification/srp_link_asserts.sv ***
`default_nettype none
`include "srp_regs.svh"

// --------------------
// Link wire checks
// --------------------
module srp_link_asserts (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  localparam int HALF = `SRP_SCLK_HALF_CYC;

  typedef struct packed {
    logic        sclk;
    logic        cpol;
    logic [6:0]  edges;
    logic [11:0] half;
  } srp_chk_s;

  srp_chk_s st_q;
  srp_chk_s st_d;
  logic     samp;

  // Sample edge: clock returns to the level seen at select fall
  assign samp = !cs_n && (sclk != st_q.sclk) && (sclk == st_q.cpol);

  // Idle level, sample-edge count, saturating half-period length
  always_comb
  begin
    st_d = st_q;
    st_d.sclk = sclk;
    st_d.half = (sclk != st_q.sclk) ? 12'h000 : st_q.half + {11'h000, st_q.half != 12'hFFF};
    if (cs_n)
    begin
      st_d.cpol = sclk;
      st_d.edges = 7'h00;
    end
    else if (samp)
      st_d.edges = st_q.edges + 7'h01;
  end

  // Tracking state
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  // Checker samples on the system clock, so every relation is in system cycles
  a_oe_released: assert property (cs_n |-> !miso_oe)
    else $error("data output driven outside a frame");
  a_cpol_setup: assert property ($fell(cs_n) |-> $past(sclk, 4) == sclk)
    else $error("clock level not settled before select fall");
  a_cpol_hold: assert property ($fell(cs_n) |-> $stable(sclk)[*4])
    else $error("clock moved too soon after select fall");
  a_mosi_setup: assert property (samp |-> $past(mosi, 4) == mosi ##1 $stable(mosi)[*2])
    else $error("master data not stable around sample edge");
  a_miso_steady: assert property (samp && miso_oe |-> $stable(miso_o) ##1 $stable(miso_o))
    else $error("device data moved at sample edge");
  a_oe_first_data: assert property ($rose(miso_oe) |-> sclk != st_q.cpol && st_q.edges == 7'h08)
    else $error("read data not started after the header");
  a_whole_bytes: assert property ($rose(cs_n) |-> st_q.edges >= 7'h08 && st_q.edges[2:0] == 3'h0)
    else $error("frame ended off a byte boundary");
  a_half_period: assert property (!cs_n && $changed(sclk) && st_q.edges != 7'h00 |-> st_q.half >= HALF - 1)
    else $error("serial clock half period too short");

  c_low_idle: cover property ($fell(cs_n) && !sclk);
  c_high_idle: cover property ($fell(cs_n) && sclk);
  c_read_data: cover property ($rose(miso_oe));
  c_long_burst: cover property ($rose(cs_n) && st_q.edges == 7'h58);
endmodule

`default_nettype wire

// *** verification/testbench.sv ***
`default_nettype none

// --------------------
// Both ends over one link
// --------------------
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import srp_pkg::*;

  logic      CLOCK, RESET_N, cmd_valid, cmd_rw, cmd_cpol, wd_valid, wr_ready, ovf_clr;
  logic      cmd_ready, wd_ready, rd_valid, wr_valid, active, overflow, cap_cpol, prev_sclk;
  srp_addr_t cmd_addr, wr_addr;
  srp_len_t  cmd_len;
  srp_byte_t wd_data, rd_data, wr_data, hdr;
  logic [3:0] nbits;
  int        num_errors, compares;

  srp_link_if link ();

  srp_master u_srp_master (.CLOCK(CLOCK), .RESET_N(RESET_N), .LINK(link.mst),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_RW(cmd_rw), .CMD_CPOL(cmd_cpol),
    .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len), .WD_VALID(wd_valid), .WD_READY(wd_ready),
    .WD_DATA(wd_data), .RD_VALID(rd_valid), .RD_DATA(rd_data));
  srp_device u_srp_device (.CLOCK(CLOCK), .RESET_N(RESET_N), .LINK(link.dev),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
    .ACTIVE(active), .OVERFLOW(overflow), .OVF_CLR(ovf_clr));
  srp_link_asserts u_srp_link_asserts (.CLOCK(CLOCK), .RESET_N(RESET_N), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe),
    .miso(link.miso));

  // 200 MHz system clock
  initial
  begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end

  // Header as seen on the wire at sample edges
  always @(posedge CLOCK)
  begin
    prev_sclk <= link.sclk;
    if (link.cs_n)
    begin
      // Keep the last header visible after the frame ends
      if (cmd_valid)
        nbits <= 4'h0;
      cap_cpol <= link.sclk;
    end
    else if (link.sclk !== prev_sclk && link.sclk === cap_cpol && nbits < 4'h8)
    begin
      hdr <= {hdr[6:0], link.mosi};
      nbits <= nbits + 4'h1;
    end
  end

  // --------------------
  // Shared tasks
  // --------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares=%0d errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bounded wait for one handshake flag; a byte takes some 6400 cycles
  task automatic wait_for(input int which);
    logic [4:0] f;
    for (int i = 0; i < 20000; i++)
    begin
      @(posedge CLOCK);
      f = {overflow, wr_valid, rd_valid, wd_ready, cmd_ready};
      if (f[which] === 1'b1)
        return;
    end
    check(16'h0000, 16'h0001);
    end_sim();
  endtask

  // One frame; read bytes expected as base, base+1, ...
  task automatic frame(input logic rw, input logic cpol, input srp_addr_t addr,
                       input srp_len_t len, input srp_byte_t base);
    cmd_valid <= 1'b1;
    cmd_rw <= rw;
    cmd_cpol <= cpol;
    cmd_addr <= addr;
    cmd_len <= len;
    wait_for(0);
    cmd_valid <= 1'b0;
    wd_valid <= !rw;
    for (int k = 0; k < int'(len); k++)
    begin
      wd_data <= base + 8'(k);
      wait_for(rw ? 2 : 1);
      if (rw)
        check({8'h00, rd_data}, {8'h00, base + 8'(k)});
    end
    wd_valid <= 1'b0;
    wait_for(0);
  endtask

  // --------------------
  // Test sequence
  // --------------------
  initial
  begin
    RESET_N = 1'b0;
    {cmd_valid, cmd_rw, cmd_cpol, wd_valid, wr_ready, ovf_clr} = '0;
    {cmd_addr, cmd_len, wd_data, hdr, nbits, num_errors, compares} = '0;
    repeat (3) @(posedge CLOCK);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    check({cmd_ready, wr_valid, overflow, active}, 16'h0008);
    check({link.cs_n, link.miso_oe}, 16'h0002);
    $display("test 1 done");
    // Ten bytes from 30 while the stream stalls: wraps, then one is lost
    frame(1'b0, 1'b0, 5'h1E, 6'h0A, 8'hA0);
    wait_for(4);
    check({15'h0000, overflow}, 16'h0001);
    for (int k = 0; k < 9; k++)
    begin
      wait_for(3);
      check({3'h0, wr_addr, wr_data}, {3'h0, 5'h1E + 5'(k), 8'hA0 + 8'(k)});
      wr_ready <= 1'b1;
      @(posedge CLOCK);
      wr_ready <= 1'b0;
    end
    repeat (4) @(posedge CLOCK);
    check({15'h0000, wr_valid}, 16'h0000);
    ovf_clr <= 1'b1;
    @(posedge CLOCK);
    ovf_clr <= 1'b0;
    repeat (2) @(posedge CLOCK);
    check({15'h0000, overflow}, 16'h0000);
    $display("test 2 done");
    // Read back across the wrap with the clock idling high
    frame(1'b1, 1'b1, 5'h1F, 6'h02, 8'hA1);
    check({4'h0, nbits, hdr}, 16'h089F);
    check({15'h0000, link.miso_oe}, 16'h0000);
    $display("test 3 done");
    end_sim();
  end
endmodule

`default_nettype wire
